// >>> rtl/fis_map.svh
`ifndef FIS_MAP_SVH
`define FIS_MAP_SVH
// Clock period of ref_clk
`define FIS_CLK_PERIOD_NS 100
// Blanking after a turn-on command, least time
`define FIS_BLANK_NS 2000
// Hardware timeout out of verification and weak modes, longest time; the mode machine leaves test mode one ref_clk cycle after it
`define FIS_TIMEOUT_US 1000
// Supervision select reset value: nothing selected
`define FIS_SEL_RESET 3'h0
`endif

// >>> rtl/fis_pkg.sv
package fis_pkg;
  // Operating modes
  typedef enum logic [1:0] {
    FIS_DEFAULT = 2'b00,
    FIS_CONFIG = 2'b01,
    FIS_VERIFY = 2'b10,
    FIS_WEAK = 2'b11
  } fis_mode_type;
  // Supervision functions
  typedef enum logic [2:0] {
    FIS_SEL_NONE = 3'b000,
    FIS_SEL_DS1 = 3'b001,
    FIS_SEL_DS2 = 3'b010,
    FIS_SEL_DS3 = 3'b011,
    FIS_SEL_OC1 = 3'b100,
    FIS_SEL_OC3 = 3'b101
  } fis_sel_type;
  // Output stage and comparator steering
  typedef struct packed {
    logic gate_on;
    logic gate_weak;
    logic desat_force;
    logic ocp_force;
  } fis_stage_type;
endpackage : fis_pkg

// >>> rtl/fis_top.sv
`timescale 1ns/100ps
`include "fis_map.svh"
module fis_top #(
  parameter int BLANK_CYC = (`FIS_BLANK_NS + `FIS_CLK_PERIOD_NS - 1) / `FIS_CLK_PERIOD_NS,
  parameter int TIMEOUT_CYC = (`FIS_TIMEOUT_US * 1000) / `FIS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Mode requests from the command decoder
  input wire logic cfg_req,
  input wire logic verify_req,
  input wire logic weak_req,
  input wire logic exit_req,
  // Supervision select, written in configuration mode
  input wire logic [2:0] supervision_sel,
  // Asynchronous pin and comparator inputs
  input wire logic pwm_input,
  input wire logic desat_cmp,
  input wire logic [1:0] ocp_cmp,
  // Error flag clear
  input wire logic err_clr,
  // Output stage and comparator steering
  output fis_pkg::fis_stage_type stage,
  // Mode and error reporting
  output fis_pkg::fis_mode_type mode,
  output logic desat_err,
  output logic ocp_err,
  output logic err_notify
);
  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers: pwm, desat, two ocp comparators
  logic [3:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  always_comb begin
    sync1_nxt = {ocp_cmp, desat_cmp, pwm_input};
    sync2_nxt = sync1_r;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end
  logic pwm_s, desat_s;
  logic [1:0] ocp_s;
  assign pwm_s = sync2_r[0];
  assign desat_s = sync2_r[1];
  assign ocp_s = sync2_r[3:2];

  ////////////////////////////////////////////////////////////////////////////////
  // Mode machine with hardware timeout
  fis_pkg::fis_mode_type mode_r, mode_nxt;
  logic [TW-1:0] tmo_r, tmo_nxt;
  logic weak_d_r, weak_d_nxt;
  logic tmo_hit;
  assign tmo_hit = (tmo_r == TW'(TIMEOUT_CYC));
  always_comb begin
    mode_nxt = mode_r;
    tmo_nxt = '0;
    weak_d_nxt = (mode_r == fis_pkg::FIS_WEAK);
    case (mode_r)
      fis_pkg::FIS_DEFAULT: begin
        if (cfg_req) mode_nxt = fis_pkg::FIS_CONFIG;
      end
      fis_pkg::FIS_CONFIG: begin
        if (exit_req) mode_nxt = fis_pkg::FIS_DEFAULT;
        else if (verify_req) mode_nxt = fis_pkg::FIS_VERIFY;
      end
      fis_pkg::FIS_VERIFY, fis_pkg::FIS_WEAK: begin
        // Timer keeps running across verify to weak so the sum is bounded
        tmo_nxt = tmo_r + TW'(1);
        if (tmo_hit || exit_req) begin
          mode_nxt = fis_pkg::FIS_DEFAULT;
          tmo_nxt = '0;
        end else if (weak_req) begin
          mode_nxt = fis_pkg::FIS_WEAK;
        end
      end
      default: mode_nxt = fis_pkg::FIS_DEFAULT;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_r <= fis_pkg::FIS_DEFAULT;
      tmo_r <= '0;
      weak_d_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      tmo_r <= tmo_nxt;
      weak_d_r <= weak_d_nxt;
    end
  end
  logic test_mode, weak_entry;
  assign test_mode = (mode_r == fis_pkg::FIS_VERIFY) || (mode_r == fis_pkg::FIS_WEAK);
  assign weak_entry = (mode_r == fis_pkg::FIS_WEAK) && !weak_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Supervision selection: captured in config, active only in test modes
  fis_pkg::fis_sel_type sel_r, sel_nxt, act_sel;
  always_comb begin
    sel_nxt = sel_r;
    if (mode_r == fis_pkg::FIS_CONFIG) sel_nxt = fis_pkg::fis_sel_type'(supervision_sel);
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) sel_r <= fis_pkg::fis_sel_type'(`FIS_SEL_RESET);
    else sel_r <= sel_nxt;
  end
  // Selection held back outside test modes so normal operation is never intruded
  assign act_sel = test_mode ? sel_r : fis_pkg::FIS_SEL_NONE;

  ////////////////////////////////////////////////////////////////////////////////
  // Blanking after each pwm turn-on command, gate driven or not
  logic [BW-1:0] blank_r, blank_nxt;
  logic blank_over;
  assign blank_over = (blank_r == BW'(BLANK_CYC));
  always_comb begin
    blank_nxt = '0;
    if (pwm_s) blank_nxt = blank_over ? blank_r : blank_r + BW'(1);
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) blank_r <= '0;
    else blank_r <= blank_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Detection and sticky error flags; set wins over clear
  logic desat_force, ocp_force, desat_in, ocp_in, desat_evt, ocp_evt, fault;
  assign desat_force = (act_sel == fis_pkg::FIS_SEL_DS1) ||
                       (act_sel == fis_pkg::FIS_SEL_DS3);
  assign ocp_force = (act_sel == fis_pkg::FIS_SEL_OC1) ||
                     (act_sel == fis_pkg::FIS_SEL_OC3);
  // Injected and genuine events share one path, so flags and reactions match
  assign desat_in = desat_force || desat_s;
  assign ocp_in = ocp_force || (|ocp_s);
  assign desat_evt = (pwm_s && blank_over && desat_in) ||
                     (weak_entry && act_sel == fis_pkg::FIS_SEL_DS3);
  assign ocp_evt = (pwm_s && blank_over && ocp_in) ||
                   (weak_entry && act_sel == fis_pkg::FIS_SEL_OC3);
  logic desat_err_r, desat_err_nxt, ocp_err_r, ocp_err_nxt, notify_r, notify_nxt;
  always_comb begin
    desat_err_nxt = desat_evt || (desat_err_r && !err_clr);
    ocp_err_nxt = ocp_evt || (ocp_err_r && !err_clr);
    // One pulse toward the primary side whenever either flag is newly raised, even if both rise together
    notify_nxt = (desat_evt && !desat_err_r) || (ocp_evt && !ocp_err_r);
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      desat_err_r <= 1'b0;
      ocp_err_r <= 1'b0;
      notify_r <= 1'b0;
    end else begin
      desat_err_r <= desat_err_nxt;
      ocp_err_r <= ocp_err_nxt;
      notify_r <= notify_nxt;
    end
  end
  assign fault = desat_err_r || ocp_err_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage steering, registered
  fis_pkg::fis_stage_type stage_r, stage_nxt;
  logic fwd;
  assign fwd = !((act_sel == fis_pkg::FIS_SEL_DS2) || (act_sel == fis_pkg::FIS_SEL_DS3) ||
                 (act_sel == fis_pkg::FIS_SEL_OC3));
  always_comb begin
    stage_nxt.gate_on = pwm_s && fwd && !fault && (mode_r != fis_pkg::FIS_CONFIG);
    stage_nxt.gate_weak = (mode_r == fis_pkg::FIS_WEAK);
    stage_nxt.desat_force = desat_force;
    stage_nxt.ocp_force = ocp_force;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) stage_r <= '0;
    else stage_r <= stage_nxt;
  end
  assign stage = stage_r;
  assign mode = mode_r;
  assign desat_err = desat_err_r;
  assign ocp_err = ocp_err_r;
  assign err_notify = notify_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ds1_force_a: assert property (act_sel == fis_pkg::FIS_SEL_DS1 |=> stage_r.desat_force)
    else $error("desat level 1 did not force comparator");
  ds1_weak_a: assert property (act_sel == fis_pkg::FIS_SEL_DS1 && mode_r == fis_pkg::FIS_WEAK
    && pwm_s && !fault |=> stage_r.gate_on && stage_r.gate_weak)
    else $error("desat level 1 did not pass weak turn-on");
  ds2_block_a: assert property (act_sel == fis_pkg::FIS_SEL_DS2 && pwm_s |=> !stage_r.gate_on)
    else $error("desat level 2 drove output stage");
  ds2_detect_a: assert property (act_sel == fis_pkg::FIS_SEL_DS2 && pwm_s && blank_over
    && desat_s |=> desat_err_r)
    else $error("desat level 2 missed error after blanking");
  ds3_entry_a: assert property ($rose(mode_r == fis_pkg::FIS_WEAK)
    && sel_r == fis_pkg::FIS_SEL_DS3 |=> desat_err_r)
    else $error("desat level 3 no error on weak entry");
  no_fwd_a: assert property (act_sel inside {fis_pkg::FIS_SEL_DS3, fis_pkg::FIS_SEL_OC3}
    |=> !stage_r.gate_on)
    else $error("pwm forwarded while blocked");
  oc1_detect_a: assert property (act_sel == fis_pkg::FIS_SEL_OC1 && pwm_s
    && blank_over |=> ocp_err_r && stage_r.ocp_force)
    else $error("overcurrent level 1 missed error");
  oc3_entry_a: assert property ($rose(mode_r == fis_pkg::FIS_WEAK)
    && sel_r == fis_pkg::FIS_SEL_OC3 |=> ocp_err_r ##1 !stage_r.gate_on)
    else $error("overcurrent level 3 no error on weak entry");
  err_report_a: assert property ($rose(fault) |-> err_notify)
    else $error("error raised without notification");
  sel_gate_a: assert property (!test_mode |-> act_sel == fis_pkg::FIS_SEL_NONE)
    else $error("selection active outside test modes");
  tmo_exit_a: assert property (test_mode && tmo_hit |=> mode_r == fis_pkg::FIS_DEFAULT)
    else $error("timeout did not return to default mode");
  weak_volt_a: assert property (mode_r == fis_pkg::FIS_WEAK |=> stage_r.gate_weak
    || mode_r != fis_pkg::FIS_WEAK)
    else $error("weak mode without reduced gate voltage");
  fault_off_a: assert property (fault |=> !stage_r.gate_on)
    else $error("gate on while fault flagged");
  ds1_run_c: cover property (act_sel == fis_pkg::FIS_SEL_DS1 ##1 $rose(desat_err_r));
  ds3_run_c: cover property ($rose(mode_r == fis_pkg::FIS_WEAK) ##1 $rose(desat_err_r));
  oc3_run_c: cover property ($rose(mode_r == fis_pkg::FIS_WEAK) ##1 $rose(ocp_err_r));
  tmo_run_c: cover property (tmo_hit ##1 mode_r == fis_pkg::FIS_DEFAULT);
endmodule : fis_top

// >>> sim/fault_injection_supervision_bench.sv
`timescale 1ns/100ps
module fault_injection_supervision_bench;
  logic ref_clk, rst_n, desat_cmp, err_clr;
  logic cfg_req, verify_req, weak_req, exit_req, pwm_input;
  logic [1:0] ocp_cmp;
  logic [2:0] supervision_sel;
  fis_pkg::fis_stage_type stage;
  fis_pkg::fis_mode_type mode;
  logic desat_err, ocp_err, err_notify;
  logic on_seen, de_seen, oc_seen;
  int pulses, err_count, compares;
  fis_ctrl_model fis_ctrl_model_inst (.ref_clk(ref_clk), .cfg_req(cfg_req),
    .verify_req(verify_req), .weak_req(weak_req), .exit_req(exit_req),
    .supervision_sel(supervision_sel), .pwm_input(pwm_input));
  // Short counts keep the run brief
  fis_top #(.BLANK_CYC(8), .TIMEOUT_CYC(50)) fis_top_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .cfg_req(cfg_req), .verify_req(verify_req),
    .weak_req(weak_req), .exit_req(exit_req), .supervision_sel(supervision_sel),
    .pwm_input(pwm_input), .desat_cmp(desat_cmp), .ocp_cmp(ocp_cmp),
    .err_clr(err_clr), .stage(stage), .mode(mode), .desat_err(desat_err),
    .ocp_err(ocp_err), .err_notify(err_notify));
  ////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Three-cycle reset also flushes the pin synchronisers
  // Pwm pin belongs to the controller model, so it is lowered through it
  task automatic do_reset;
    fis_ctrl_model_inst.set_pwm(1'b0);
    {rst_n, desat_cmp, err_clr} = 3'h0;
    ocp_cmp = 2'h0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
  endtask : do_reset
  // Collects what the outputs did over n cycles, sampled at falling edges
  task automatic watch(input int n);
    {on_seen, de_seen, oc_seen} = 3'h0;
    pulses = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      on_seen |= stage.gate_on;
      de_seen |= desat_err;
      oc_seen |= ocp_err;
      if (err_notify === 1'b1) pulses++;
    end
  endtask : watch
  ////////////////////////////////////////////////////////////////////////
  task automatic ds1_test;
    do_reset();
    fis_ctrl_model_inst.enter_weak(3'h1);
    chk(stage.desat_force, 1'b1);
    fis_ctrl_model_inst.set_pwm(1'b1);
    watch(4);
    chk({on_seen, de_seen}, 2'b10);
    chk(stage.gate_weak, 1'b1);
    watch(12);
    chk({de_seen, oc_seen}, 2'b10);
    chk(pulses[7:0], 8'h01);
    chk(stage.gate_on, 1'b0);
    fis_ctrl_model_inst.set_pwm(1'b0);
    err_clr = 1'b1;
    @(negedge ref_clk);
    // Pwm still high behind the synchroniser: the event beats the clear
    chk(desat_err, 1'b1);
    repeat (2) @(negedge ref_clk);
    err_clr = 1'b0;
    chk(desat_err, 1'b0);
  endtask : ds1_test
  // Pin left undriven rises, but blanking must hold it off first
  task automatic ds2_test;
    do_reset();
    fis_ctrl_model_inst.enter_weak(3'h2);
    fis_ctrl_model_inst.set_pwm(1'b1);
    desat_cmp = 1'b1;
    watch(4);
    chk({on_seen, de_seen}, 2'b00);
    watch(12);
    chk({on_seen, de_seen, pulses[0]}, 3'b011);
  endtask : ds2_test
  task automatic ds3_test;
    do_reset();
    fis_ctrl_model_inst.enter_weak(3'h3);
    watch(4);
    chk({on_seen, de_seen, oc_seen}, 3'b010);
    chk(pulses[7:0], 8'h01);
  endtask : ds3_test
  task automatic oc1_test;
    do_reset();
    fis_ctrl_model_inst.enter_weak(3'h4);
    chk(stage.ocp_force, 1'b1);
    fis_ctrl_model_inst.set_pwm(1'b1);
    watch(4);
    chk({on_seen, oc_seen}, 2'b10);
    watch(12);
    chk({de_seen, oc_seen, pulses[0]}, 3'b011);
  endtask : oc1_test
  // Pwm high throughout must neither reach the gate nor matter
  task automatic oc3_test;
    do_reset();
    fis_ctrl_model_inst.enter_weak(3'h5);
    fis_ctrl_model_inst.set_pwm(1'b1);
    watch(6);
    chk({on_seen, de_seen, oc_seen}, 3'b001);
  endtask : oc3_test
  // Genuine overcurrent on one comparator, no supervision selected
  task automatic ocp_genuine_test;
    do_reset();
    fis_ctrl_model_inst.set_pwm(1'b1);
    ocp_cmp = 2'h2;
    watch(16);
    chk({4'h0, on_seen, de_seen, oc_seen, pulses[0]}, 8'h0b);
    chk(stage.gate_on, 1'b0);
    fis_ctrl_model_inst.set_pwm(1'b0);
    ocp_cmp = 2'h0;
  endtask : ocp_genuine_test
  // Leaving test modes early must drop the forced comparator one cycle after the mode returns to default
  task automatic exit_test;
    do_reset();
    fis_ctrl_model_inst.enter_weak(3'h1);
    chk(stage.desat_force, 1'b1);
    fis_ctrl_model_inst.leave();
    @(negedge ref_clk);
    chk({5'h00, stage.desat_force, mode}, 8'h00);
  endtask : exit_test
  // Checks the cycle just before and just after the timeout fires
  task automatic tmo_test;
    do_reset();
    fis_ctrl_model_inst.enter_weak(3'h0);
    watch(49);
    chk({6'h00, mode}, 8'h03);
    watch(1);
    chk({6'h00, mode}, 8'h00);
  endtask : tmo_test
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, desat_cmp, err_clr} = 3'h0;
    ocp_cmp = 2'h0;
    ds1_test();
    ds2_test();
    ds3_test();
    oc1_test();
    oc3_test();
    ocp_genuine_test();
    exit_test();
    tmo_test();
    print_verdict();
  end
  // Watchdog well beyond the roughly two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
endmodule : fault_injection_supervision_bench

// >>> sim/fis_ctrl_model.sv
`timescale 1ns/100ps
// Primary-side controller: mode commands, selection and pwm pin
module fis_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Commands towards the block
  output logic cfg_req,
  output logic verify_req,
  output logic weak_req,
  output logic exit_req,
  output logic [2:0] supervision_sel,
  output logic pwm_input
);
  // Plateau fixed at zero in every run, level 3 included; no port carries it
  localparam logic [3:0] PLATEAU_VAL = 4'h0;
  initial begin
    {cfg_req, verify_req, weak_req, exit_req, pwm_input} = 5'h00;
    supervision_sel = 3'h0;
  end
  // One function chosen in configuration, then verify and weak in turn
  task automatic enter_weak(input logic [2:0] sel);
    @(negedge ref_clk);
    cfg_req = 1'b1;
    supervision_sel = sel;
    @(negedge ref_clk);
    cfg_req = 1'b0;
    verify_req = 1'b1;
    @(negedge ref_clk);
    verify_req = 1'b0;
    weak_req = 1'b1;
    @(negedge ref_clk);
    weak_req = 1'b0;
  endtask : enter_weak
  // Exit request wins over a pending verify or weak request
  task automatic leave;
    @(negedge ref_clk);
    exit_req = 1'b1;
    @(negedge ref_clk);
    exit_req = 1'b0;
  endtask : leave
  // Pin level changes only off the sampling edge
  task automatic set_pwm(input logic v);
    @(negedge ref_clk);
    pwm_input = v;
  endtask : set_pwm
endmodule : fis_ctrl_model
